// ===== bench/t8oc_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module t8oc_cpu_model (
  input  wire logic                    i_core_clk,
  output var  t8oc_pkg::t8oc_axi_req_t o_req,
  input  wire t8oc_pkg::t8oc_axi_rsp_t i_rsp
);
  import t8oc_pkg::*;
  initial o_req = '0;
  // ready is raised only after valid is seen: a slow core
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge i_core_clk);
    o_req.awaddr <= a;
    o_req.wdata <= d;
    o_req.wstrb <= 4'hF;
    o_req.awvalid <= 1'h1;
    o_req.wvalid <= 1'h1;
    // no cycle count assumed; only the bench watchdog ends a wait
    while (!i_rsp.bvalid) begin
      @(posedge i_core_clk);
      if (i_rsp.awready) o_req.awvalid <= 1'h0;
      if (i_rsp.wready) o_req.wvalid <= 1'h0;
    end
    o_req.bready <= 1'h1;
    @(posedge i_core_clk);
    r = i_rsp.bresp;
    o_req.bready <= 1'h0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge i_core_clk);
    o_req.araddr <= a;
    o_req.arvalid <= 1'h1;
    while (!i_rsp.rvalid) begin
      @(posedge i_core_clk);
      if (i_rsp.arready) o_req.arvalid <= 1'h0;
    end
    o_req.rready <= 1'h1;
    @(posedge i_core_clk);
    d = i_rsp.rdata;
    r = i_rsp.rresp;
    o_req.rready <= 1'h0;
  endtask
endmodule // t8oc_cpu_model
`default_nettype wire

// ===== bench/t8oc_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "t8oc_regs.svh"
module t8oc_sva (
  input wire logic                    i_core_clk,
  input wire logic                    i_rst,
  input wire t8oc_pkg::t8oc_axi_req_t i_axi,
  input wire t8oc_pkg::t8oc_axi_rsp_t o_axi,
  input wire logic                    i_global_irq_enable,
  input wire logic                    o_compare_irq,
  input wire logic                    o_overflow_irq,
  input wire logic                    o_waveform_output,
  input wire logic                    o_pin_drive_en
);
  import t8oc_pkg::*;
  // address of the read in flight, so read data can be judged
  logic [`T8OC_AW-1:0] rd_a;
  always_ff @(posedge i_core_clk)
    if (i_axi.arvalid && o_axi.arready) rd_a <= i_axi.araddr;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_wr_take;
    i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready;
  endsequence
  sequence s_wr_ans;
    ##[1:3] o_axi.bvalid;
  endsequence
  a_wave_rst: assert property ($fell(i_rst) |-> !o_waveform_output)
    else $error("waveform not cleared by reset");
  a_cmp_irq_gate: assert property (
    !i_global_irq_enable |=> !o_compare_irq)
    else $error("compare irq without global enable");
  a_ovf_irq_gate: assert property (
    !i_global_irq_enable |=> !o_overflow_irq)
    else $error("overflow irq without global enable");
  a_wr_answer: assert property (s_wr_take |-> s_wr_ans)
    else $error("write not answered");
  a_rd_answer: assert property (
    i_axi.arvalid && o_axi.arready |=> o_axi.rvalid)
    else $error("read not answered");
  a_b_stands: assert property (
    o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid && $stable(o_axi.bresp))
    else $error("write response dropped");
  a_r_stands: assert property (
    o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata))
    else $error("read data dropped");
  a_force_rd0: assert property (
    o_axi.rvalid && rd_a == `T8OC_OFS_CTRL
    |-> !o_axi.rdata[`T8OC_CTRL_FORCE])
    else $error("force strobe reads one");
  a_drive_by_wr: assert property (
    $changed(o_pin_drive_en) |-> o_axi.bvalid)
    else $error("pin drive moved without write");
endmodule // t8oc_sva
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "t8oc_regs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb;
  import t8oc_pkg::*;
  localparam logic [4:0] CT = `T8OC_OFS_CTRL, CN = `T8OC_OFS_COUNT;
  localparam logic [4:0] CP = `T8OC_OFS_COMPARE, FL = `T8OC_OFS_FLAGS;
  logic          core_clk, rst, ptick, glob, cack, oack;
  logic          cirq, oirq, wave, drv;
  t8oc_axi_req_t req;
  t8oc_axi_rsp_t rsp;
  int            miscompares, samples_checked;
  t8oc_top dut (.i_core_clk(core_clk), .i_rst(rst), .i_axi(req),
    .o_axi(rsp), .i_prescale_tick(ptick), .i_ext_tick_pin(1'h0),
    .i_global_irq_enable(glob), .i_compare_irq_ack(cack),
    .i_overflow_irq_ack(oack), .o_compare_irq(cirq), .o_overflow_irq(oirq),
    .o_waveform_output(wave), .o_pin_drive_en(drv));
  t8oc_cpu_model u_cpu (.i_core_clk(core_clk), .o_req(req), .i_rsp(rsp));
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] cw(t8oc_com_t m, t8oc_wgm_t g,
                                     logic [2:0] s, logic f);
    return {24'h0, f, m, g, s};
  endfunction
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_cpu.wr(a, d, r);
    `CHK(r, `T8OC_RESP_OKAY)
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    u_cpu.rd(a, d, r);
    `CHK({r, d}, {`T8OC_RESP_OKAY, 24'h0, e})
  endtask
  // prescaler pulses spaced out so each lands on its own
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      ptick <= 1'h1;
      @(posedge core_clk);
      ptick <= 1'h0;
      @(posedge core_clk);
    end
  endtask
  task automatic ack(input logic c);
    @(posedge core_clk);
    cack <= c;
    oack <= !c;
    @(posedge core_clk);
    cack <= 1'h0;
    oack <= 1'h0;
  endtask
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rd(CT, 8'h00);
    rd(CN, 8'h00);
    `CHK(wave, 1'h0)
    u_cpu.rd(5'h18, d, r);
    `CHK({r, d}, {`T8OC_RESP_SLVERR, 32'h0})
  endtask
  task automatic t_stop;
    wr(CN, 32'h05);
    tick(3);
    rd(CN, 8'h05);
  endtask
  task automatic t_normal;
    wr(CT, cw(T8OC_COM_OFF, T8OC_WGM_NORMAL, 3'h2, 1'h0));
    wr(CP, 32'h80);
    wr(CN, 32'hFE);
    tick(1);
    rd(CN, 8'hFF);
    rd(FL, 8'h00);
    tick(1);
    rd(CN, 8'h00);
    rd(FL, 8'h01);
    wr(`T8OC_OFS_IRQEN, 32'h03);
    `CHK(oirq, 1'h1)
    ack(1'h0);
    rd(FL, 8'h00);
    `CHK(oirq, 1'h0)
  endtask
  task automatic t_compare;
    wr(CP, 32'h10);
    wr(CN, 32'h10);
    tick(1);
    rd(FL, 8'h00);
    wr(CN, 32'h0F);
    tick(2);
    rd(FL, 8'h02);
    `CHK(cirq, 1'h1)
    @(posedge core_clk);
    glob <= 1'h0;
    repeat (3) @(posedge core_clk);
    `CHK(cirq, 1'h0)
    glob <= 1'h1;
    ack(1'h1);
    rd(FL, 8'h00);
    wr(CN, 32'h0F);
    tick(2);
    wr(FL, 32'h02);
    rd(FL, 8'h00);
  endtask
  task automatic t_ctc;
    wr(CT, cw(T8OC_COM_TOGGLE, T8OC_WGM_CTC, 3'h2, 1'h0));
    wr(CP, 32'h03);
    wr(CN, 32'h00);
    tick(4);
    rd(CN, 8'h00);
    `CHK(wave, 1'h1)
    `CHK(drv, 1'h1)
  endtask
  // force strobes move the waveform while the pin is driven; the level holds when the pin drive is released
  task automatic t_force;
    wr(FL, 32'h03);
    wr(CT, cw(T8OC_COM_TOGGLE, T8OC_WGM_NORMAL, 3'h0, 1'h1));
    `CHK(wave, 1'h0)
    rd(FL, 8'h00);
    rd(CT, 8'h20);
    wr(CT, cw(T8OC_COM_SET, T8OC_WGM_NORMAL, 3'h0, 1'h1));
    `CHK(wave, 1'h1)
    wr(CP, 32'h05);
    wr(CT, cw(T8OC_COM_OFF, T8OC_WGM_FAST, 3'h0, 1'h0));
    `CHK(wave, 1'h1)
    `CHK(drv, 1'h0)
  endtask
  task automatic t_pwm;
    wr(CT, cw(T8OC_COM_CLEAR, T8OC_WGM_FAST, 3'h2, 1'h0));
    wr(CN, 32'h04);
    wr(CP, 32'h40);
    rd(CP, 8'h40);
    tick(2);
    `CHK(wave, 1'h0)
    wr(CN, 32'hFF);
    tick(1);
    `CHK(wave, 1'h1)
    wr(CN, 32'h3E);
    tick(3);
    `CHK(wave, 1'h0)
  endtask
  // dual slope: reload at top, set on the down-slope match
  task automatic t_pcpwm;
    wr(FL, 32'h03);
    wr(CT, cw(T8OC_COM_CLEAR, T8OC_WGM_PCPWM, 3'h2, 1'h0));
    wr(CP, 32'hFD);
    wr(CN, 32'hFE);
    tick(4);
    `CHK(wave, 1'h1)
    rd(FL, 8'h02);
    rd(`T8OC_OFS_STATUS, 8'h07);
  endtask
  task automatic end_sim;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rst = 1'h1;
    ptick = 1'h0;
    glob = 1'h1;
    cack = 1'h0;
    oack = 1'h0;
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    t_reset;
    t_stop;
    t_normal;
    t_compare;
    t_ctc;
    t_force;
    t_pwm;
    t_pcpwm;
    end_sim;
  end
  // the whole run is a few hundred cycles; this cuts a hang
  initial begin
    #50000;
    miscompares++;
    end_sim;
  end
endmodule // tb
bind t8oc_top t8oc_sva u_sva (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_axi(i_axi), .o_axi(o_axi), .i_global_irq_enable(i_global_irq_enable),
  .o_compare_irq(o_compare_irq), .o_overflow_irq(o_overflow_irq),
  .o_waveform_output(o_waveform_output), .o_pin_drive_en(o_pin_drive_en));
`default_nettype wire

// ===== verilog/t8oc_pkg.sv
`default_nettype none
`include "t8oc_regs.svh"
package t8oc_pkg;

  typedef enum logic [1:0] {
    T8OC_WGM_NORMAL = 2'h0,
    T8OC_WGM_PCPWM  = 2'h1,
    T8OC_WGM_CTC    = 2'h2,
    T8OC_WGM_FAST   = 2'h3
  } t8oc_wgm_t;

  typedef enum logic [1:0] {
    T8OC_COM_OFF    = 2'h0,
    T8OC_COM_TOGGLE = 2'h1,
    T8OC_COM_CLEAR  = 2'h2,
    T8OC_COM_SET    = 2'h3
  } t8oc_com_t;

  typedef struct packed {
    logic       force_compare_strobe;
    t8oc_com_t  compare_output_mode;
    t8oc_wgm_t  waveform_mode;
    logic [2:0] clock_select;
  } t8oc_ctrl_t;

  typedef struct packed {
    logic                   awvalid;
    logic [`T8OC_AW-1:0]    awaddr;
    logic                   wvalid;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bready;
    logic                   arvalid;
    logic [`T8OC_AW-1:0]    araddr;
    logic                   rready;
  } t8oc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } t8oc_axi_rsp_t;

endpackage
`default_nettype wire

// ===== verilog/t8oc_regs.svh
`ifndef T8OC_REGS_SVH
`define T8OC_REGS_SVH
// Notes on behaviour
// - each tick clears, increments or decrements count
// - clock select zero stops all ticks
// - software reads and writes count anytime
// - software count write beats tick operation
// - waveform mode picks sequence and waveform
// - overflow flag set per mode, raises interrupt
// - eight-bit comparator flags count equals compare
// - match flag set on tick after match
// - compare irq when flag, enable, global set
// - flag clears on acknowledge or written one
// - waveform from match, modes, max, bottom
// - compare buffered in PWM modes only
// - buffer copied to active at top/bottom; the code copies at top (max) only
// - compare access hits buffer or active register
// - force strobe acts like match, non-PWM only
// - count write blocks matches on next tick
// - waveform register holds across mode changes
// - output mode changes take effect immediately
// - output mode sets match action, pin drive
// - reset clears waveform register
// - normal mode wraps, overflow when becoming zero
// - clear-on-compare clears count, mode 1 toggles
// - fast PWM single slope, mode 2/3 polarity

`define T8OC_AW            5
`define T8OC_OFS_CTRL      5'h00
`define T8OC_OFS_COUNT     5'h04
`define T8OC_OFS_COMPARE   5'h08
`define T8OC_OFS_FLAGS     5'h0C
`define T8OC_OFS_IRQEN     5'h10
`define T8OC_OFS_STATUS    5'h14

`define T8OC_CTRL_FORCE    7
`define T8OC_FLAG_OVF      0
`define T8OC_FLAG_CMP      1
`define T8OC_STAT_WAVE     0
`define T8OC_STAT_DOWN     1
`define T8OC_STAT_DRIVE    2

`define T8OC_RST_BYTE      8'h00
`define T8OC_CNT_MAX       8'hFF
`define T8OC_CNT_BOTTOM    8'h00
`define T8OC_CNT_STEP      8'h01

`define T8OC_CS_STOP       3'h0
`define T8OC_CS_CORE       3'h1
`define T8OC_CS_PIN_FALL   3'h6
`define T8OC_CS_PIN_RISE   3'h7

`define T8OC_RESP_OKAY     2'h0
`define T8OC_RESP_SLVERR   2'h2
`endif

// ===== verilog/t8oc_tick_sel.sv
`timescale 1ns/100ps
`default_nettype none
`include "t8oc_regs.svh"
module t8oc_tick_sel (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_clock_select,
  input  wire logic       i_prescale_tick,
  input  wire logic       i_ext_tick_pin,
  output wire logic       o_tick
);
  logic pin_meta;
  logic pin_sync;
  logic pin_last;
  // pin_meta feeds only pin_sync
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_last <= 1'b0;
    end else begin
      pin_meta <= i_ext_tick_pin;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  wire logic pin_rise = pin_sync & ~pin_last;
  wire logic pin_fall = ~pin_sync & pin_last;

  // codes between core and pin edges take the prescaler tap
  assign o_tick = (i_clock_select == `T8OC_CS_STOP)     ? 1'b0 :
                  (i_clock_select == `T8OC_CS_CORE)     ? 1'b1 :
                  (i_clock_select == `T8OC_CS_PIN_FALL) ? pin_fall :
                  (i_clock_select == `T8OC_CS_PIN_RISE) ? pin_rise :
                  i_prescale_tick;
endmodule // t8oc_tick_sel
`default_nettype wire

// ===== verilog/t8oc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "t8oc_regs.svh"
module t8oc_top (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rst,
  input  wire t8oc_pkg::t8oc_axi_req_t i_axi,
  output var  t8oc_pkg::t8oc_axi_rsp_t o_axi,
  input  wire logic                    i_prescale_tick,
  input  wire logic                    i_ext_tick_pin,
  input  wire logic                    i_global_irq_enable,
  input  wire logic                    i_compare_irq_ack,
  input  wire logic                    i_overflow_irq_ack,
  output var  logic                    o_compare_irq,
  output var  logic                    o_overflow_irq,
  output var  logic                    o_waveform_output,
  output var  logic                    o_pin_drive_en
);
  import t8oc_pkg::*;

  function automatic logic wave_on_match(input t8oc_com_t com,
                                         input logic      cur);
    logic res;
    res = cur;
    unique case (com)
      T8OC_COM_OFF:    res = cur;
      T8OC_COM_TOGGLE: res = ~cur;
      T8OC_COM_CLEAR:  res = 1'b0;
      T8OC_COM_SET:    res = 1'b1;
    endcase
    return res;
  endfunction

  function automatic logic [7:0] bit_of(input logic [31:0] word,
                                        input logic        sel);
    return sel ? word[7:0] : `T8OC_RST_BYTE;
  endfunction

  // register state
  t8oc_ctrl_t          ctrl;
  logic [7:0]          count_value;
  logic [7:0]          compare_value;
  logic [7:0]          compare_buf;
  logic                overflow_flag;
  logic                compare_match_flag;
  logic                overflow_irq_enable;
  logic                compare_irq_enable;
  logic                waveform_output;
  logic                count_down;
  logic                block_match;

  // bus state
  logic                aw_held;
  logic [`T8OC_AW-1:0] aw_addr;
  logic                w_held;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;

  wire logic tick;

  t8oc_tick_sel u_tick (
    .i_core_clk      (i_core_clk),
    .i_rst           (i_rst),
    .i_clock_select  (ctrl.clock_select),
    .i_prescale_tick (i_prescale_tick),
    .i_ext_tick_pin  (i_ext_tick_pin),
    .o_tick          (tick)
  );

  // ---------------- bus slave ----------------
  wire logic aw_take = i_axi.awvalid & o_axi.awready;
  wire logic w_take  = i_axi.wvalid & o_axi.wready;
  wire logic ar_take = i_axi.arvalid & o_axi.arready;
  wire logic wr_do   = aw_held & w_held & ~o_axi.bvalid;
  wire logic wr_lo   = wr_do & w_strb[0];

  wire logic next_aw_held = aw_take | (aw_held & ~wr_do);
  wire logic next_w_held  = w_take | (w_held & ~wr_do);
  wire logic next_bvalid  = wr_do | (o_axi.bvalid & ~i_axi.bready);
  wire logic next_rvalid  = ar_take | (o_axi.rvalid & ~i_axi.rready);

  wire logic wr_hit_ctrl  = aw_addr == `T8OC_OFS_CTRL;
  wire logic wr_hit_count = aw_addr == `T8OC_OFS_COUNT;
  wire logic wr_hit_cmp   = aw_addr == `T8OC_OFS_COMPARE;
  wire logic wr_hit_flags = aw_addr == `T8OC_OFS_FLAGS;
  wire logic wr_hit_irqen = aw_addr == `T8OC_OFS_IRQEN;
  wire logic wr_hit_stat  = aw_addr == `T8OC_OFS_STATUS;
  wire logic wr_mapped    = wr_hit_ctrl | wr_hit_count | wr_hit_cmp |
                            wr_hit_flags | wr_hit_irqen | wr_hit_stat;

  wire logic wr_ctrl  = wr_lo & wr_hit_ctrl;
  wire logic wr_count = wr_lo & wr_hit_count;
  wire logic wr_cmp   = wr_lo & wr_hit_cmp;
  wire logic wr_flags = wr_lo & wr_hit_flags;
  wire logic wr_irqen = wr_lo & wr_hit_irqen;

  wire logic buffered = (ctrl.waveform_mode == T8OC_WGM_PCPWM) |
                        (ctrl.waveform_mode == T8OC_WGM_FAST);

  wire logic [7:0] status_byte = {5'h00,
                                  o_pin_drive_en,
                                  count_down,
                                  waveform_output};
  wire logic [7:0] ctrl_rd = {1'b0, ctrl[6:0]};
  wire logic [7:0] cmp_rd  = buffered ? compare_buf
                                      : compare_value;
  wire logic [7:0] flag_rd = {6'h00, compare_match_flag, overflow_flag};
  wire logic [7:0] irq_rd  = {6'h00, compare_irq_enable,
                              overflow_irq_enable};

  wire logic rd_ctrl  = i_axi.araddr == `T8OC_OFS_CTRL;
  wire logic rd_count = i_axi.araddr == `T8OC_OFS_COUNT;
  wire logic rd_cmp   = i_axi.araddr == `T8OC_OFS_COMPARE;
  wire logic rd_flags = i_axi.araddr == `T8OC_OFS_FLAGS;
  wire logic rd_irqen = i_axi.araddr == `T8OC_OFS_IRQEN;
  wire logic rd_stat  = i_axi.araddr == `T8OC_OFS_STATUS;
  wire logic rd_mapped = rd_ctrl | rd_count | rd_cmp |
                         rd_flags | rd_irqen | rd_stat;
  wire logic [7:0] rd_byte = rd_ctrl  ? ctrl_rd :
                             rd_count ? count_value :
                             rd_cmp   ? cmp_rd :
                             rd_flags ? flag_rd :
                             rd_irqen ? irq_rd :
                             rd_stat  ? status_byte :
                             `T8OC_RST_BYTE;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      if (aw_take) aw_addr <= i_axi.awaddr;
      if (w_take) begin
        w_data <= i_axi.wdata;
        w_strb <= i_axi.wstrb;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_axi <= '{awready: 1'b1, wready: 1'b1, bvalid: 1'b0,
                 bresp: `T8OC_RESP_OKAY, arready: 1'b1, rvalid: 1'b0,
                 rdata: 32'h0000_0000, rresp: `T8OC_RESP_OKAY};
    end else begin
      o_axi.awready <= ~next_aw_held & ~next_bvalid;
      o_axi.wready  <= ~next_w_held & ~next_bvalid;
      o_axi.bvalid  <= next_bvalid;
      o_axi.arready <= ~next_rvalid;
      o_axi.rvalid  <= next_rvalid;
      if (wr_do) begin
        o_axi.bresp <= wr_mapped ? `T8OC_RESP_OKAY : `T8OC_RESP_SLVERR;
      end
      if (ar_take) begin
        o_axi.rdata <= {24'h00_0000, rd_byte};
        o_axi.rresp <= rd_mapped ? `T8OC_RESP_OKAY : `T8OC_RESP_SLVERR;
      end
    end
  end

  // ---------------- counter ----------------
  wire logic at_max    = count_value == `T8OC_CNT_MAX;
  wire logic at_bottom = count_value == `T8OC_CNT_BOTTOM;
  wire logic match     = count_value == compare_value;
  // a blocked tick loses its match entirely, clear included
  wire logic match_ok  = tick & match & ~block_match;

  // dual slope turns at max and at bottom
  wire logic pc_down = count_down ? ~at_bottom : at_max;
  wire logic [7:0] count_up   = count_value + `T8OC_CNT_STEP;
  wire logic [7:0] count_dn   = count_value - `T8OC_CNT_STEP;

  wire logic [7:0] count_step =
    (ctrl.waveform_mode == T8OC_WGM_CTC)   ?
      (match_ok ? `T8OC_CNT_BOTTOM : count_up) :
    (ctrl.waveform_mode == T8OC_WGM_PCPWM) ?
      (pc_down ? count_dn : count_up) :
    count_up;

  wire logic [7:0] next_count =
    wr_count ? w_data[7:0] :
    tick     ? count_step :
    count_value;

  wire logic next_down = (ctrl.waveform_mode == T8OC_WGM_PCPWM) &
                         (tick ? pc_down : count_down);

  wire logic next_block = wr_count | (block_match & ~tick);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      count_value <= `T8OC_RST_BYTE;
      count_down  <= 1'b0;
      block_match <= 1'b0;
    end else begin
      count_value <= next_count;
      count_down  <= next_down;
      block_match <= next_block;
    end
  end

  // ---------------- compare value ----------------
  // top of the slope is the reload point in both PWM modes
  wire logic reload = buffered & tick & at_max;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      compare_value <= `T8OC_RST_BYTE;
      compare_buf   <= `T8OC_RST_BYTE;
    end else begin
      if (wr_cmp & buffered) compare_buf <= w_data[7:0];
      if (wr_cmp & ~buffered) begin
        compare_value <= w_data[7:0];
      end else if (reload) begin
        compare_value <= compare_buf;
      end
    end
  end

  // ---------------- control and flags ----------------
  wire t8oc_ctrl_t next_ctrl = wr_ctrl ?
    t8oc_ctrl_t'({1'b0, w_data[6:0]}) : ctrl;

  wire logic ovf_set =
    (ctrl.waveform_mode == T8OC_WGM_PCPWM) ?
      (tick & at_bottom & count_down) :
      (tick & at_max);
  wire logic ovf_clr = i_overflow_irq_ack |
                       (wr_flags & w_data[`T8OC_FLAG_OVF]);
  wire logic cmp_clr = i_compare_irq_ack |
                       (wr_flags & w_data[`T8OC_FLAG_CMP]);

  // a set in the clearing cycle survives
  wire logic next_ovf_flag = ovf_set | (overflow_flag & ~ovf_clr);
  wire logic next_cmp_flag = match_ok |
                             (compare_match_flag & ~cmp_clr);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl                <= t8oc_ctrl_t'(`T8OC_RST_BYTE);
      overflow_flag       <= 1'b0;
      compare_match_flag  <= 1'b0;
      overflow_irq_enable <= 1'b0;
      compare_irq_enable  <= 1'b0;
    end else begin
      ctrl               <= next_ctrl;
      overflow_flag      <= next_ovf_flag;
      compare_match_flag <= next_cmp_flag;
      if (wr_irqen) begin
        overflow_irq_enable <= w_data[`T8OC_FLAG_OVF];
        compare_irq_enable  <= w_data[`T8OC_FLAG_CMP];
      end
    end
  end

  // ---------------- waveform ----------------
  // force has no effect in PWM modes and never touches flag or count
  wire logic force_ok = wr_ctrl & w_data[`T8OC_CTRL_FORCE] &
                        ~buffered;
  wire t8oc_com_t com = ctrl.compare_output_mode;
  wire logic pwm_pol  = com[1];
  wire logic pwm_lvl  = com[0];

  logic next_wave;
  always_comb begin
    next_wave = waveform_output;
    unique case (ctrl.waveform_mode)
      T8OC_WGM_NORMAL, T8OC_WGM_CTC: begin
        if (match_ok | force_ok) begin
          next_wave = wave_on_match(com, waveform_output);
        end
      end
      T8OC_WGM_FAST: begin
        // match wins at max so a max compare holds the level
        if (pwm_pol & match_ok) begin
          next_wave = pwm_lvl;
        end else if (pwm_pol & tick & at_max) begin
          next_wave = ~pwm_lvl;
        end
      end
      T8OC_WGM_PCPWM: begin
        if (pwm_pol & match_ok) begin
          next_wave = count_down ? ~pwm_lvl : pwm_lvl;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      waveform_output <= 1'b0;
    end else begin
      waveform_output <= next_wave;
    end
  end

  // ---------------- outputs ----------------
  // one cycle behind the flag; ack drops the request a cycle later
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_compare_irq     <= 1'b0;
      o_overflow_irq    <= 1'b0;
      o_waveform_output <= 1'b0;
      o_pin_drive_en    <= 1'b0;
    end else begin
      o_compare_irq  <= compare_match_flag & compare_irq_enable &
                        i_global_irq_enable;
      o_overflow_irq <= overflow_flag & overflow_irq_enable &
                        i_global_irq_enable;
      o_waveform_output <= next_wave;
      o_pin_drive_en <= next_ctrl.compare_output_mode !=
                        T8OC_COM_OFF;
    end
  end

  wire logic unused_ok = &{1'b0, w_strb[3:1], w_data[31:8]};
endmodule // t8oc_top
`default_nettype wire
